// File: evtimer_pkg.sv
// Constants, register map and field layout of the event-driven timer.
// Functional notes
// R1: Main control bit 0 enables the timer; cleared keeps it inactive.
// R2: Clock select: 0 peripheral clock, 1 half rate, 2 companion clock, 3 reserved.
// R3: Run-in-standby keeps operating in standby, ignored with companion clock selected.
// R4: Restart-with-companion restarts the counter when the companion counter restarts.
// R5: Mode 0 periodic, 1 time-out, 6 single-shot, 7 eight-bit PWM.
// R6: Modes 2..5 capture, frequency, pulse width, combined frequency and pulse width.
// R7: Single-shot output rises at count start, or at event when immediate set.
// R8: Initial-level bit gives the output starting state when output in use.
// R9: Output gate 0 forces output low; 1 passes mode-dependent value.
// R10: Filter bit enables four-sample noise canceller before edge detection.
// R11: Periodic mode ignores event edges of both polarities.
// R12: Capture mode: selected edge captures count and raises flag.
// R13: Frequency mode: selected edge captures, clears, restarts, raises flag.
// R14: Pulse-width mode: one edge restarts, opposite edge captures and flags.
// R15: Combined mode: restart, capture on opposite edge, stop and flag on next.
// R16: Time-out mode: one edge starts counter, opposite edge stops it.
// R17: Single-shot: only selected edge starts counter, other ignored.
// R18: Events act only while trigger-input-enable is set.
// R19: Capture flag clears on write one or compare read in capture mode.
// R20: Status counting flag reads one while running, zero when stopped.
package evtimer_pkg;
    localparam logic [3:0] OFF_MAIN    = 4'h0;
    localparam logic [3:0] OFF_MODE    = 4'h1;
    localparam logic [3:0] OFF_TRIG    = 4'h4;
    localparam logic [3:0] OFF_IRQEN   = 4'h5;
    localparam logic [3:0] OFF_IRQF    = 4'h6;
    localparam logic [3:0] OFF_STATUS  = 4'h7;
    localparam logic [3:0] OFF_HALT    = 4'h8;
    localparam logic [3:0] OFF_STAGE   = 4'h9;
    localparam logic [3:0] OFF_CNT     = 4'hA;
    localparam logic [3:0] OFF_CMP     = 4'hC;
    localparam logic [3:0] OFF_SYSCTL  = 4'hE;
    localparam int BIT_ENABLE   = 0;
    localparam int BIT_CLK_SRC  = 1;
    localparam int BIT_RESYNC   = 4;
    localparam int BIT_STBY_RUN = 6;
    localparam int BIT_IMMED    = 6;
    localparam int BIT_INIT     = 5;
    localparam int BIT_GATE     = 4;
    localparam int BIT_FILTER   = 6;
    localparam int BIT_EDGE     = 4;
    localparam int BIT_TRIGEN   = 0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] CLK_FULL = 2'h0;
    localparam logic [1:0] CLK_HALF = 2'h1;
    localparam logic [1:0] CLK_COMP = 2'h2;
    localparam logic [2:0] M_PERIODIC = 3'h0;
    localparam logic [2:0] M_TIMEOUT  = 3'h1;
    localparam logic [2:0] M_CAPTURE  = 3'h2;
    localparam logic [2:0] M_FREQ     = 3'h3;
    localparam logic [2:0] M_PWIDTH   = 3'h4;
    localparam logic [2:0] M_FREQPW   = 3'h5;
    localparam logic [2:0] M_SINGLE   = 3'h6;
    localparam logic [2:0] M_PWM8     = 3'h7;
    localparam int FILTER_TAPS = 4;
    typedef enum logic [2:0] {
        CMB_IDLE = 3'b001,
        CMB_HIGH = 3'b010,
        CMB_LOW  = 3'b100
    } combined_e;
endpackage

// File: evtimer.sv
// Event-driven 16-bit timer with AXI4-Lite register access.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module evtimer (
    input  wire logic        CORE_CLK_I,
    input  wire logic        RST_B_I,
    input  wire logic [5:0]  S_AXI_AWADDR_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    output logic [1:0]       S_AXI_BRESP_O,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    input  wire logic [5:0]  S_AXI_ARADDR_I,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    input  wire logic        EVENT_I,
    input  wire logic        COMPANION_TICK_I,
    input  wire logic        COMPANION_RESTART_I,
    input  wire logic        STANDBY_I,
    input  wire logic        CPU_HALT_I,
    output logic             COMPARE_OUT_O,
    output logic             CAPTURE_STROBE_O,
    output logic             IRQ_REQ_O
);

    ////////////////////////////////////////////////////////////////////////
    // Register bus slave.

    logic [7:0]  main_ff, mode_ff, trig_ff, irqen_ff, halt_ff, stage_ff;
    logic        flag_ff;
    logic [15:0] cnt_ff, cmp_ff;
    logic        run_ff;
    logic        aw_ff, w_ff;
    logic [3:0]  awidx_ff;
    logic [7:0]  wbyte_ff;
    logic        wdone;
    logic        rd_go;
    logic [3:0]  ridx;
    logic [7:0]  rbyte;
    logic        map_ok_w, map_ok_r;

    // Registers are byte wide; each occupies one aligned word, low byte used.
    assign wdone = aw_ff & w_ff & ~S_AXI_BVALID_O;
    assign rd_go = S_AXI_ARVALID_I & ~S_AXI_RVALID_O;
    assign ridx  = S_AXI_ARADDR_I[5:2];

    // Index check, shared by both directions.
    function automatic logic mapped(input logic [3:0] idx);
        mapped = (idx <= evtimer_pkg::OFF_SYSCTL) && (idx != 4'h2) && (idx != 4'h3);
    endfunction
    assign map_ok_w = mapped(awidx_ff);
    assign map_ok_r = mapped(ridx);

    // Address and data are held separately so they may arrive in either order.
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            aw_ff    <= 1'b0;
            w_ff     <= 1'b0;
            awidx_ff <= 4'h0;
            wbyte_ff <= 8'h00;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_ff    <= 1'b1;
                awidx_ff <= S_AXI_AWADDR_I[5:2];
            end else if (wdone) begin
                aw_ff <= 1'b0;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_ff     <= 1'b1;
                wbyte_ff <= S_AXI_WSTRB_I[0] ? S_AXI_WDATA_I[7:0] : 8'h00;
            end else if (wdone) begin
                w_ff <= 1'b0;
            end
        end
    end

    // Ready flops and responses; a write answers one edge after both parts are taken.
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O  <= 1'b0;
            S_AXI_BVALID_O  <= 1'b0;
            S_AXI_BRESP_O   <= 2'h0;
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_RDATA_O   <= 32'h0000_0000;
            S_AXI_RRESP_O   <= 2'h0;
        end else begin
            S_AXI_AWREADY_O <= ~aw_ff & ~S_AXI_AWREADY_O & S_AXI_AWVALID_I;
            S_AXI_WREADY_O  <= ~w_ff & ~S_AXI_WREADY_O & S_AXI_WVALID_I;
            if (wdone) begin
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O  <= map_ok_w ? 2'h0 : 2'h2;
            end else if (S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
            S_AXI_ARREADY_O <= rd_go & ~S_AXI_ARREADY_O;
            if (rd_go && S_AXI_ARREADY_O) begin
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RDATA_O  <= {24'h00_0000, rbyte};
                S_AXI_RRESP_O  <= map_ok_r ? 2'h0 : 2'h2;
            end else if (S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end

    // Read multiplexer; 16-bit registers read low byte at offset, high at +1.
    always_comb begin
        case (ridx)
            evtimer_pkg::OFF_MAIN:        rbyte = main_ff;
            evtimer_pkg::OFF_MODE:        rbyte = mode_ff;
            evtimer_pkg::OFF_TRIG:        rbyte = trig_ff;
            evtimer_pkg::OFF_IRQEN:       rbyte = irqen_ff;
            evtimer_pkg::OFF_IRQF:        rbyte = {7'h00, flag_ff};
            evtimer_pkg::OFF_STATUS:      rbyte = {7'h00, run_ff & en}; // R20
            evtimer_pkg::OFF_HALT:        rbyte = halt_ff;
            evtimer_pkg::OFF_STAGE:       rbyte = stage_ff;
            evtimer_pkg::OFF_CNT:         rbyte = cnt_ff[7:0];
            evtimer_pkg::OFF_CNT + 4'h1:  rbyte = cnt_ff[15:8];
            evtimer_pkg::OFF_CMP:         rbyte = cmp_ff[7:0];
            evtimer_pkg::OFF_CMP + 4'h1:  rbyte = cmp_ff[15:8];
            default:                      rbyte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Field decode.

    logic       en, trig_en, edge_sel, filt_en, immed, init_lvl, gate;
    logic [1:0] clk_src;
    logic [2:0] mode;
    logic       wr_hit;
    logic       capture_mode;
    logic       cmp_read;

    assign en        = main_ff[evtimer_pkg::BIT_ENABLE];
    assign clk_src   = main_ff[evtimer_pkg::BIT_CLK_SRC +: 2];
    assign mode      = mode_ff[2:0];
    assign immed     = mode_ff[evtimer_pkg::BIT_IMMED];
    assign init_lvl  = mode_ff[evtimer_pkg::BIT_INIT];
    assign gate      = mode_ff[evtimer_pkg::BIT_GATE];
    assign filt_en   = trig_ff[evtimer_pkg::BIT_FILTER];
    assign edge_sel  = trig_ff[evtimer_pkg::BIT_EDGE];
    assign trig_en   = trig_ff[evtimer_pkg::BIT_TRIGEN];
    assign capture_mode = (mode >= evtimer_pkg::M_CAPTURE) && (mode <= evtimer_pkg::M_FREQPW);
    assign cmp_read  = rd_go & S_AXI_ARREADY_O &
                       ((ridx == evtimer_pkg::OFF_CMP) || (ridx == evtimer_pkg::OFF_CMP + 4'h1));

    function automatic logic wr_at(input logic [3:0] a, input logic [3:0] b, input logic go);
        wr_at = go && (a == b);
    endfunction
    assign wr_hit = wdone;

    ////////////////////////////////////////////////////////////////////////
    // Event input: three-flop synchroniser, optional filter, edge detect.

    logic [2:0] sync_ff;
    logic       stable;
    logic [3:0] hist_ff;
    logic       lvl_ff;
    logic       nxt_lvl;
    logic       rise, fall;

    // The third flop agreeing with the second marks a settled input.
    assign stable = (sync_ff[1] == sync_ff[2]);
    // Filter accepts a level only after four equal samples; adds latency.
    assign nxt_lvl = filt_en ? ((&hist_ff) ? 1'b1 : ((|hist_ff) ? lvl_ff : 1'b0)) // R10
                             : (stable ? sync_ff[2] : lvl_ff);
    assign rise = nxt_lvl & ~lvl_ff;
    assign fall = ~nxt_lvl & lvl_ff;

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            sync_ff <= 3'h0;
            hist_ff <= 4'h0;
            lvl_ff  <= 1'b0;
        end else begin
            sync_ff <= {sync_ff[1:0], EVENT_I};
            if (stable) begin
                hist_ff <= {hist_ff[2:0], sync_ff[2]};
            end
            lvl_ff <= nxt_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock enable and active gating.

    logic half_ff;
    logic active;
    logic tick;

    // Standby stops the unit unless run-in-standby; companion clock ignores it.
    assign active = en & ~(STANDBY_I & ~(main_ff[evtimer_pkg::BIT_STBY_RUN] & // R1 R3
                    (clk_src != evtimer_pkg::CLK_COMP))) &
                    ~(CPU_HALT_I & ~halt_ff[0]);
    assign tick = active & ((clk_src == evtimer_pkg::CLK_FULL) | // R2
                            ((clk_src == evtimer_pkg::CLK_HALF) & half_ff) |
                            ((clk_src == evtimer_pkg::CLK_COMP) & COMPANION_TICK_I));

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            half_ff <= 1'b0;
        end else begin
            half_ff <= en ? ~half_ff : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode engine.

    logic       ev_on;
    logic       pos, neg;
    logic [7:0] cmp_lo, cmp_hi;
    logic       at_top;
    evtimer_pkg::combined_e cmb_ff;
    logic       restart, capture, stop, start, set_flag;
    logic       out_ff;

    // Events act only when enabled and never in periodic or PWM mode.
    assign ev_on = active & trig_en & (mode != evtimer_pkg::M_PERIODIC) & // R18 R11
                   (mode != evtimer_pkg::M_PWM8);
    assign pos = ev_on & (edge_sel ? fall : rise);
    assign neg = ev_on & (edge_sel ? rise : fall);
    assign cmp_lo = cmp_ff[7:0];
    assign cmp_hi = cmp_ff[15:8];
    assign at_top = (mode == evtimer_pkg::M_PWM8) ? (cnt_ff[7:0] >= cmp_lo) : (cnt_ff >= cmp_ff);

    // Per-mode edge actions.
    always_comb begin
        restart = 1'b0;
        capture = 1'b0;
        stop    = 1'b0;
        start   = 1'b0;
        case (mode)
            evtimer_pkg::M_TIMEOUT: begin
                start = pos; // R16
                stop  = neg; // R16
            end
            evtimer_pkg::M_CAPTURE: begin
                capture = pos; // R12
            end
            evtimer_pkg::M_FREQ: begin
                capture = pos; // R13
                restart = pos; // R13
            end
            evtimer_pkg::M_PWIDTH: begin
                restart = pos; // R14
                capture = neg; // R14
            end
            evtimer_pkg::M_FREQPW: begin
                restart = pos & (cmb_ff == evtimer_pkg::CMB_IDLE) & ~flag_ff; // R15
                capture = neg & (cmb_ff == evtimer_pkg::CMB_HIGH); // R15
                stop    = pos & (cmb_ff == evtimer_pkg::CMB_LOW); // R15
            end
            evtimer_pkg::M_SINGLE: begin
                start = pos & ~run_ff; // R17
            end
            default: begin
                start = 1'b0;
            end
        endcase
    end

    // Flag sources: captures, combined stop, top in counting modes.
    assign set_flag = (capture & (mode != evtimer_pkg::M_FREQPW)) | // R6
                      (stop & (mode == evtimer_pkg::M_FREQPW)) |
                      (tick & run_ff & at_top & ~capture_mode);

    // Combined mode sequencer.
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            cmb_ff <= evtimer_pkg::CMB_IDLE;
        end else if (mode != evtimer_pkg::M_FREQPW || !en) begin
            cmb_ff <= evtimer_pkg::CMB_IDLE;
        end else begin
            case (cmb_ff)
                evtimer_pkg::CMB_IDLE: if (restart) cmb_ff <= evtimer_pkg::CMB_HIGH;
                evtimer_pkg::CMB_HIGH: if (capture) cmb_ff <= evtimer_pkg::CMB_LOW;
                evtimer_pkg::CMB_LOW:  if (stop)    cmb_ff <= evtimer_pkg::CMB_IDLE;
                default:               cmb_ff <= evtimer_pkg::CMB_IDLE;
            endcase
        end
    end

    // Counter, run state and capture; software writes win over counting.
    // A low-byte write only stages; the high byte commits both, so no torn value is seen.
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            cnt_ff <= 16'h0000;
            cmp_ff <= 16'h0000;
            run_ff <= 1'b0;
        end else begin
            if (!en) begin
                run_ff <= (mode != evtimer_pkg::M_TIMEOUT) && (mode != evtimer_pkg::M_SINGLE);
            end else if (start || restart) begin
                run_ff <= 1'b1;
            end else if (stop || (tick && at_top && mode == evtimer_pkg::M_SINGLE)) begin
                run_ff <= 1'b0;
            end
            if (wr_at(awidx_ff, evtimer_pkg::OFF_CNT + 4'h1, wr_hit)) begin
                cnt_ff <= {wbyte_ff, stage_ff};
            end else if (restart || start || (main_ff[evtimer_pkg::BIT_RESYNC] &&
                         COMPANION_RESTART_I && en)) begin
                cnt_ff <= 16'h0000; // R4
            end else if (tick && run_ff) begin
                cnt_ff <= (at_top && !capture_mode) ? 16'h0000 : cnt_ff + 16'h0001;
            end
            if (wr_at(awidx_ff, evtimer_pkg::OFF_CMP + 4'h1, wr_hit)) begin
                cmp_ff <= {wbyte_ff, stage_ff};
            end else if (capture) begin
                cmp_ff <= cnt_ff; // R12 R13 R14
            end
        end
    end

    // Control registers, staging byte and sticky flag (set wins over clear).
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            main_ff  <= evtimer_pkg::RST_BYTE;
            mode_ff  <= evtimer_pkg::RST_BYTE;
            trig_ff  <= evtimer_pkg::RST_BYTE;
            irqen_ff <= evtimer_pkg::RST_BYTE;
            halt_ff  <= evtimer_pkg::RST_BYTE;
            stage_ff <= evtimer_pkg::RST_BYTE;
            flag_ff  <= 1'b0;
        end else begin
            if (wr_at(awidx_ff, evtimer_pkg::OFF_MAIN, wr_hit))  main_ff  <= wbyte_ff & 8'h57;
            if (wr_at(awidx_ff, evtimer_pkg::OFF_MODE, wr_hit))  mode_ff  <= wbyte_ff & 8'h77;
            if (wr_at(awidx_ff, evtimer_pkg::OFF_TRIG, wr_hit))  trig_ff  <= wbyte_ff & 8'h51;
            if (wr_at(awidx_ff, evtimer_pkg::OFF_IRQEN, wr_hit)) irqen_ff <= wbyte_ff & 8'h01;
            if (wr_at(awidx_ff, evtimer_pkg::OFF_HALT, wr_hit))  halt_ff  <= wbyte_ff & 8'h01;
            if (wr_at(awidx_ff, evtimer_pkg::OFF_STAGE, wr_hit) ||
                wr_at(awidx_ff, evtimer_pkg::OFF_CNT, wr_hit) ||
                wr_at(awidx_ff, evtimer_pkg::OFF_CMP, wr_hit)) begin
                stage_ff <= wbyte_ff;
            end
            if (set_flag) begin
                flag_ff <= 1'b1;
            end else if ((wr_at(awidx_ff, evtimer_pkg::OFF_IRQF, wr_hit) && wbyte_ff[0]) ||
                         (cmp_read && capture_mode)) begin
                flag_ff <= 1'b0; // R19
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output shaping.

    logic nxt_out;

    // Single-shot rises at start or at event; PWM compares; else initial level.
    always_comb begin
        case (mode)
            evtimer_pkg::M_SINGLE: nxt_out = (immed & ev_on & (edge_sel ? fall : rise)) | // R7
                                              start | (run_ff & ~(tick & at_top) & out_ff);
            evtimer_pkg::M_PWM8:   nxt_out = en & (cnt_ff[7:0] < cmp_hi) & (cmp_lo != 8'h00);
            default:               nxt_out = init_lvl; // R8
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            out_ff           <= 1'b0;
            COMPARE_OUT_O    <= 1'b0;
            CAPTURE_STROBE_O <= 1'b0;
            IRQ_REQ_O        <= 1'b0;
        end else begin
            out_ff           <= nxt_out;
            COMPARE_OUT_O    <= gate & nxt_out; // R9
            CAPTURE_STROBE_O <= set_flag;
            IRQ_REQ_O        <= (flag_ff | set_flag) & irqen_ff[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_gate;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I) !gate |=> !COMPARE_OUT_O;
    endproperty
    a_gate: assert property (p_gate) else $error("Output not forced low."); // R9

    property p_periodic;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
            (mode == evtimer_pkg::M_PERIODIC) |-> !capture && !restart;
    endproperty
    a_periodic: assert property (p_periodic) else $error("Edge acted in periodic."); // R11

    property p_trig;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I) !trig_en |-> !capture && !start;
    endproperty
    a_trig: assert property (p_trig) else $error("Event acted while disabled."); // R18

    property p_capture_val;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
            capture && !wr_hit |=> cmp_ff == $past(cnt_ff);
    endproperty
    a_capture_val: assert property (p_capture_val) else $error("Capture value wrong."); // R12

    property p_flag;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I) set_flag |=> flag_ff && CAPTURE_STROBE_O;
    endproperty
    a_flag: assert property (p_flag) else $error("Flag not set."); // R19

    property p_freq;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I)
            (mode == evtimer_pkg::M_FREQ) && capture && !wr_hit |=> cnt_ff == 16'h0000;
    endproperty
    a_freq: assert property (p_freq) else $error("Counter not restarted."); // R13

    property p_off;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I) !en |-> !tick;
    endproperty
    a_off: assert property (p_off) else $error("Counting while disabled."); // R1

    property p_start;
        @(posedge CORE_CLK_I) disable iff (!RST_B_I) en && start |=> run_ff;
    endproperty
    a_start: assert property (p_start) else $error("Run not set on start."); // R20

endmodule

// File: evtimer_partner.sv
// Event channel and companion timer model facing the timer.
`timescale 1ns/10ps
module evtimer_partner (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic level_i,
    input  wire logic restart_i,
    output logic      event_o,
    output logic      tick_o,
    output logic      restart_o
);
    // The channel delivers the level one clock late; the companion ticks every other cycle.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            event_o   <= 1'b0;
            tick_o    <= 1'b0;
            restart_o <= 1'b0;
        end else begin
            event_o   <= level_i;
            tick_o    <= ~tick_o;
            restart_o <= restart_i;
        end
    end
endmodule

// File: evtimer_tb.sv
// Self-checking testbench of the event-driven timer.
`timescale 1ns/10ps
module evtimer_tb;
    logic clk = 0, rst_b = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, lvl = 0, rq = 0;
    logic [5:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, rdata, d;
    logic [1:0]  bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, cout, irq, ev_w, tk_w, rs_w;
    int failures = 0, cmp_count = 0, cyc = 0;
    evtimer evtimer_inst (.CORE_CLK_I(clk), .RST_B_I(rst_b), .S_AXI_AWADDR_I(awa),
        .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wd),
        .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(br),
        .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rr), .EVENT_I(ev_w), .COMPANION_TICK_I(tk_w),
        .COMPANION_RESTART_I(rs_w), .STANDBY_I(1'b0), .CPU_HALT_I(1'b0),
        .COMPARE_OUT_O(cout), .CAPTURE_STROBE_O(), .IRQ_REQ_O(irq));
    evtimer_partner evtimer_partner_inst (.clk_i(clk), .rst_b_i(rst_b), .level_i(lvl),
        .restart_i(rq), .event_o(ev_w), .tick_o(tk_w), .restart_o(rs_w));
    // Clock of 25 ns and a watchdog that cuts a hang short.
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Verdict and counts.
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d.", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Value comparison.
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // Bus write; ready is looked at on the falling edge, where it stays till the next rise.
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        logic na, nw, ta, tw;
        ta = 0;
        tw = 0;
        @(posedge clk);
        awa <= a; wd <= {24'h0, v}; awv <= 1; wv <= 1; br <= 1;
        while (!(ta && tw)) begin
            @(negedge clk);
            na = !ta && awready === 1'b1;
            nw = !tw && wready === 1'b1;
            @(posedge clk);
            if (na) awv <= 0;
            if (nw) wv <= 0;
            ta |= na;
            tw |= nw;
        end
        do @(negedge clk); while (bvalid !== 1'b1);
        @(posedge clk);
        br <= 0;
    endtask
    // Bus read returning data and response.
    task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] s);
        @(posedge clk);
        ara <= a; arv <= 1; rr <= 1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arv <= 0;
        do @(negedge clk); while (rvalid !== 1'b1);
        v = rdata;
        s = rresp;
        @(posedge clk);
        rr <= 0;
    endtask
    // Read one register and compare it.
    task automatic rc(input string n, input logic [5:0] a, input logic [7:0] e);
        rd(a, d, r);
        chk(n, {24'h0, e}, d);
    endtask
    // Move the event level and let the synchroniser settle.
    task automatic ev(input logic v);
        @(posedge clk);
        lvl <= v;
        repeat (12) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Byte addresses are four times the offsets.
    task automatic t_reset();
        rc("main_rst", 6'h00, 8'h00);
        rc("mode_rst", 6'h04, 8'h00);
        rc("trig_rst", 6'h10, 8'h00);
        rd(6'h08, d, r);
        chk("unmapped_resp", 32'h2, {30'h0, r});
        chk("unmapped_data", 32'h0, d);
        wr(6'h0C, 8'h5A);
        chk("unmapped_wr", 32'h2, {30'h0, bresp});
    endtask
    // Capture on both edge settings, flag clearing and trigger gating.
    task automatic t_capture();
        wr(6'h30, 8'hFF); wr(6'h34, 8'hFF);
        wr(6'h04, 8'h02); wr(6'h14, 8'h01); wr(6'h10, 8'h01); wr(6'h00, 8'h01);
        ev(1); rc("latch_rise", 6'h18, 8'h01);
        chk("irq_line", 32'h1, {31'h0, irq});
        rd(6'h30, d, r); rc("clr_by_read", 6'h18, 8'h00);
        ev(0); rc("latch_fall", 6'h18, 8'h00);
        wr(6'h10, 8'h11); ev(1); rc("latch_rise1", 6'h18, 8'h00);
        ev(0); rc("latch_fall1", 6'h18, 8'h01);
        wr(6'h18, 8'h01); rc("clr_by_w1", 6'h18, 8'h00);
        wr(6'h10, 8'h10); ev(1); ev(0); rc("trig_off", 6'h18, 8'h00);
    endtask
    // Frequency, pulse-width and time-out edge actions.
    task automatic t_modes();
        wr(6'h04, 8'h03); wr(6'h10, 8'h01);
        ev(1); rc("freq_rise", 6'h18, 8'h01);
        wr(6'h18, 8'h01); wr(6'h04, 8'h04);
        ev(0); rc("pw_fall", 6'h18, 8'h01);
        wr(6'h18, 8'h01); ev(1); rc("pw_rise", 6'h18, 8'h00);
        wr(6'h00, 8'h00); wr(6'h04, 8'h01); wr(6'h00, 8'h01);
        rc("to_idle", 6'h1C, 8'h00);
        ev(0); ev(1); rc("to_start", 6'h1C, 8'h01);
        ev(0); rc("to_stop", 6'h1C, 8'h00);
        wr(6'h00, 8'h00); ev(1); rc("disabled", 6'h1C, 8'h00);
    endtask
    // Periodic mode ignores events; output gate and initial level.
    task automatic t_periodic();
        wr(6'h04, 8'h20); wr(6'h30, 8'hFF); wr(6'h34, 8'hFF);
        wr(6'h18, 8'h01); wr(6'h00, 8'h01);
        ev(0); ev(1); rc("per_events", 6'h18, 8'h00);
        rc("per_runs", 6'h1C, 8'h01);
        chk("gate_off", 32'h0, {31'h0, cout});
        wr(6'h04, 8'h30); repeat (4) @(posedge clk);
        chk("init_high", 32'h1, {31'h0, cout});
        wr(6'h04, 8'h10); repeat (4) @(posedge clk);
        chk("init_low", 32'h0, {31'h0, cout});
    endtask
    // Combined mode: restart, capture, then stop with the flag on the next rise.
    task automatic t_combined();
        wr(6'h04, 8'h05); wr(6'h18, 8'h01);
        ev(0); ev(1); ev(0); rc("cmb_mid", 6'h18, 8'h00);
        ev(1); rc("cmb_flag", 6'h18, 8'h01);
        rc("cmb_halt", 6'h1C, 8'h00);
    endtask
    // Companion restart clears a stopped counter; the filter drops a short glitch.
    task automatic t_sync();
        wr(6'h04, 8'h01); wr(6'h28, 8'h55); wr(6'h2C, 8'h00);
        rc("cnt_set", 6'h28, 8'h55);
        wr(6'h00, 8'h11); @(posedge clk) rq <= 1; @(posedge clk) rq <= 0;
        rc("cnt_sync", 6'h28, 8'h00);
        wr(6'h04, 8'h02); wr(6'h10, 8'h41); ev(0); wr(6'h18, 8'h01);
        @(posedge clk) lvl <= 1; repeat (2) @(posedge clk); lvl <= 0;
        ev(0); rc("filt_glitch", 6'h18, 8'h00);
        ev(1); rc("filt_pass", 6'h18, 8'h01);
    endtask
    // Main sequence after a 16-cycle reset.
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        t_reset();
        t_capture();
        t_modes();
        t_periodic();
        t_combined();
        t_sync();
        tally_and_finish();
    end
endmodule
